// ---- core/jog_pkg.sv ----
// Constants shared by the jog-mode parameter and sequencing logic.
// Assumes a 100 MHz core clock and 16-bit parameter addresses.
package jog_pkg;

	////////////////////////////////////////////////////////////////////////
	localparam logic [15:0] ADDR_INPUT_METHOD = 16'h0530;
	localparam logic [15:0] ADDR_BUS_METHOD   = 16'h2906;
	localparam logic [15:0] ADDR_SLOW_VEL     = 16'h2908;
	localparam logic [15:0] ADDR_FAST_VEL     = 16'h290A;
	localparam logic [15:0] ADDR_STEP_DIST    = 16'h290E;
	localparam logic [15:0] ADDR_DWELL        = 16'h2910;
	localparam logic [15:0] ADDR_MOVE_WORD    = 16'h1B12;

	////////////////////////////////////////////////////////////////////////
	localparam logic [15:0] RST_INPUT_METHOD = 16'h0001;
	localparam logic [15:0] RST_BUS_METHOD   = 16'h0001;
	localparam logic [31:0] RST_SLOW_VEL     = 32'h0000_003C;
	localparam logic [31:0] RST_FAST_VEL     = 32'h0000_00B4;
	localparam logic [31:0] RST_STEP_DIST    = 32'h0000_0014;
	localparam logic [15:0] RST_DWELL        = 16'h01F4;
	localparam logic [15:0] RST_MOVE_WORD    = 16'h0000;

	localparam logic [31:0] MAX_POS32  = 32'h7FFF_FFFF;
	localparam logic [15:0] MAX_DWELL  = 16'h7FFF;
	localparam logic [15:0] MAX_MOVE   = 16'h0007;
	localparam logic [15:0] METHOD_MAX = 16'h0001;

	localparam int MW_POS  = 0;
	localparam int MW_NEG  = 1;
	localparam int MW_FAST = 2;

	////////////////////////////////////////////////////////////////////////
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS         = 1000000;
	localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;

	typedef enum {
		ST_IDLE,
		ST_STEP,
		ST_DWELL,
		ST_CONT,
		ST_STOP
	} jog_state_t;

endpackage

// ---- core/jog_mode_parameter_control.sv ----
// Jog-mode parameter store and movement sequencer for one servo axis.
// Assumes the motion core executes step and run commands and reports
// step completion and standstill, all synchronous to core_clk.
//
// What this block does
// RULE1 - Holds slow jog velocity, 1..2147483647, reset 60, used at once.
// RULE2 - Holds fast jog velocity, 1..2147483647, reset 180, used at once.
// RULE3 - Applied jog velocity is clamped to the ramp maximum velocity.
// RULE4 - Only in local mode, a fast/slow input picks the jog velocity.
// RULE5 - Outside party must configure the input for fast/slow select.
// RULE6 - Input jog method: 0 continuous, 1 step, reset 1, next move.
// RULE7 - Bus jog method: 0 continuous, 1 step, reset 1, used at once.
// RULE8 - Step distance 1..2147483647, reset 20, taken at next move.
// RULE9 - Dwell time in ms 1..32767, reset 500, taken at next move.
// RULE10 - Step mode moves step distance, then stands still for dwell.
// RULE11 - Standstill monitoring offered only while step method is active.
// RULE12 - Held request in step mode: step, dwell, then continuous motion.
// RULE13 - Bus master writes move word: bit0 pos, bit1 neg, bit2 fast.
// RULE14 - Jog ends at standstill with no request, halt, stop or error.
// RULE15 - Method selector chosen by request origin, inputs or fieldbus.
`timescale 1ns/1ps
module jog_mode_parameter_control
	import jog_pkg::*;
#(
	parameter int MS_CYCLES = CYCLES_PER_MS
) (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic        param_wr,
	input  wire logic        param_rd,
	input  wire logic [15:0] param_addr,
	input  wire logic [31:0] param_wdata,
	output logic      [31:0] param_rdata,
	output logic             param_ack,
	output logic             param_err,
	input  wire logic        local_mode,
	input  wire logic        sig_jog_pos,
	input  wire logic        sig_jog_neg,
	input  wire logic        sig_fast_sel,
	input  wire logic        fast_sel_func_en,
	input  wire logic [31:0] ramp_v_max,
	input  wire logic        step_done,
	input  wire logic        motor_standstill,
	input  wire logic        halt_req,
	input  wire logic        quick_stop,
	input  wire logic        error_detected,
	output logic             jog_active,
	output logic             move_neg,
	output logic      [31:0] move_velocity,
	output logic             step_start,
	output logic      [31:0] step_target,
	output logic             run_enable,
	output logic             standstill_mon_en
);
	import jog_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic [15:0] input_jog_method_select;
	logic [15:0] bus_jog_method_select;
	logic [31:0] jog_slow_velocity;
	logic [31:0] jog_fast_velocity;
	logic [31:0] jog_step_distance;
	logic [15:0] jog_step_dwell_time;
	logic [15:0] manual_move_request_word;

	logic        wr_ok;
	logic        mapped;
	logic [31:0] next_rdata;

	// Out-of-range writes are refused whole so velocities, step distance and dwell are never zero.
	always_comb begin
		mapped     = 1'b1;
		wr_ok      = 1'b0;
		next_rdata = 32'h0000_0000;
		case (param_addr)
			ADDR_INPUT_METHOD: begin
				next_rdata = {16'h0000, input_jog_method_select};
				wr_ok      = param_wdata <= {16'h0000, METHOD_MAX};
			end
			ADDR_BUS_METHOD: begin
				next_rdata = {16'h0000, bus_jog_method_select};
				wr_ok      = param_wdata <= {16'h0000, METHOD_MAX};
			end
			ADDR_SLOW_VEL: begin
				next_rdata = jog_slow_velocity;
				wr_ok      = param_wdata != 32'h0000_0000
					&& param_wdata <= MAX_POS32;
			end
			ADDR_FAST_VEL: begin
				next_rdata = jog_fast_velocity;
				wr_ok      = param_wdata != 32'h0000_0000
					&& param_wdata <= MAX_POS32;
			end
			ADDR_STEP_DIST: begin
				next_rdata = jog_step_distance;
				wr_ok      = param_wdata != 32'h0000_0000
					&& param_wdata <= MAX_POS32;
			end
			ADDR_DWELL: begin
				next_rdata = {16'h0000, jog_step_dwell_time};
				wr_ok      = param_wdata != 32'h0000_0000
					&& param_wdata <= {16'h0000, MAX_DWELL};
			end
			ADDR_MOVE_WORD: begin
				next_rdata = {16'h0000, manual_move_request_word};
				wr_ok      = param_wdata <= {16'h0000, MAX_MOVE};
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	logic do_wr;
	assign do_wr = param_wr && wr_ok;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			input_jog_method_select  <= RST_INPUT_METHOD; // [RULE6]
			bus_jog_method_select    <= RST_BUS_METHOD; // [RULE7]
			jog_slow_velocity        <= RST_SLOW_VEL; // [RULE1]
			jog_fast_velocity        <= RST_FAST_VEL; // [RULE2]
			jog_step_distance        <= RST_STEP_DIST; // [RULE8]
			jog_step_dwell_time      <= RST_DWELL; // [RULE9]
			manual_move_request_word <= RST_MOVE_WORD;
		end else if (do_wr) begin
			case (param_addr)
				ADDR_INPUT_METHOD: input_jog_method_select <= param_wdata[15:0];
				ADDR_BUS_METHOD:   bus_jog_method_select <= param_wdata[15:0];
				ADDR_SLOW_VEL:     jog_slow_velocity <= param_wdata; // [RULE1]
				ADDR_FAST_VEL:     jog_fast_velocity <= param_wdata; // [RULE2]
				ADDR_STEP_DIST:    jog_step_distance <= param_wdata;
				ADDR_DWELL:        jog_step_dwell_time <= param_wdata[15:0];
				ADDR_MOVE_WORD:    manual_move_request_word <= param_wdata[15:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			param_ack   <= 1'b0;
			param_err   <= 1'b0;
			param_rdata <= 32'h0000_0000;
		end else begin
			param_ack   <= param_wr || param_rd;
			param_err   <= (param_wr && !wr_ok) || (param_rd && !mapped);
			param_rdata <= param_rd ? next_rdata : param_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outside local mode a word request has priority; opposing directions together mean none.
	logic bus_pos, bus_neg, bus_origin, req_pos, req_neg, req_any;
	logic use_fast, live_step, stop_cause;
	logic [31:0] sel_vel;

	assign bus_pos    = manual_move_request_word[MW_POS]; // [RULE13]
	assign bus_neg    = manual_move_request_word[MW_NEG]; // [RULE13]
	assign bus_origin = !local_mode && (bus_pos || bus_neg);
	assign req_pos    = bus_origin ? bus_pos : sig_jog_pos;
	assign req_neg    = bus_origin ? bus_neg : sig_jog_neg;
	assign req_any    = req_pos ^ req_neg;
	assign stop_cause = halt_req || quick_stop || error_detected;

	always_comb begin
		use_fast = 1'b0;
		if (bus_origin) begin
			use_fast = manual_move_request_word[MW_FAST];
		end else if (local_mode && fast_sel_func_en) begin
			use_fast = sig_fast_sel; // [RULE4]
		end
		sel_vel = use_fast ? jog_fast_velocity : jog_slow_velocity;
		if (sel_vel > ramp_v_max) begin
			sel_vel = ramp_v_max; // [RULE3]
		end
	end

	// Bus method is read live; the input method is sampled at move start.
	assign live_step = bus_origin ? bus_jog_method_select[0] // [RULE15]
		: input_jog_method_select[0]; // [RULE15]

	////////////////////////////////////////////////////////////////////////
	jog_state_t  state;
	logic        dir_neg_latched;
	logic        method_step;
	logic [15:0] dwell_ms;
	logic [15:0] ms_left;
	logic [31:0] ms_div;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			state           <= ST_IDLE;
			dir_neg_latched <= 1'b0;
			method_step     <= 1'b0;
			dwell_ms        <= RST_DWELL;
			ms_left         <= 16'h0000;
			ms_div          <= 32'h0000_0000;
			step_start      <= 1'b0;
			step_target     <= 32'h0000_0000;
		end else begin
			step_start <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (req_any && !stop_cause) begin
						dir_neg_latched <= req_neg;
						method_step     <= live_step; // [RULE6]
						dwell_ms        <= jog_step_dwell_time; // [RULE9]
						if (live_step) begin
							step_target <= jog_step_distance; // [RULE8] [RULE10]
							step_start  <= 1'b1;
							state       <= ST_STEP;
						end else begin
							state <= ST_CONT;
						end
					end
				end
				ST_STEP: begin
					// A short request still completes the whole step.
					if (stop_cause) begin
						state <= ST_STOP; // [RULE14]
					end else if (step_done) begin
						ms_left <= dwell_ms;
						ms_div  <= 32'(MS_CYCLES - 1);
						state   <= (req_any && req_neg == dir_neg_latched)
							? ST_DWELL : ST_STOP; // [RULE12]
					end
				end
				ST_DWELL: begin
					if (stop_cause || !req_any
						|| req_neg != dir_neg_latched) begin
						state <= ST_STOP; // [RULE14]
					end else if (ms_div != 32'h0000_0000) begin
						ms_div <= ms_div - 32'h0000_0001;
					end else if (ms_left > 16'h0001) begin
						ms_left <= ms_left - 16'h0001; // [RULE10]
						ms_div  <= 32'(MS_CYCLES - 1);
					end else begin
						state <= ST_CONT; // [RULE12]
					end
				end
				ST_CONT: begin
					if (stop_cause || !req_any
						|| req_neg != dir_neg_latched) begin
						state <= ST_STOP; // [RULE14]
					end else if (bus_origin && bus_jog_method_select[0]
						&& !method_step) begin
						method_step <= 1'b1; // [RULE7]
					end
				end
				ST_STOP: begin
					if (motor_standstill && (!req_any || stop_cause)) begin
						state <= ST_IDLE; // [RULE14]
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			jog_active        <= 1'b0;
			run_enable        <= 1'b0;
			move_neg          <= 1'b0;
			move_velocity     <= 32'h0000_0000;
			standstill_mon_en <= 1'b0;
		end else begin
			jog_active        <= state != ST_IDLE; // [RULE14]
			run_enable        <= state == ST_CONT;
			move_neg          <= dir_neg_latched;
			move_velocity     <= sel_vel; // [RULE1] [RULE2] [RULE3]
			standstill_mon_en <= state != ST_IDLE && method_step; // [RULE11]
		end
	end

endmodule

// ---- dv/jog_properties.sv ----
// Checker for the jog parameter port and the jog sequencer outputs.
// Assumes binding into the design top; sees its ports only.
`timescale 1ns/1ps
module jog_properties (
	input wire logic        core_clk,
	input wire logic        rst_b,
	input wire logic        param_wr,
	input wire logic        param_rd,
	input wire logic        param_ack,
	input wire logic        param_err,
	input wire logic [31:0] ramp_v_max,
	input wire logic [31:0] move_velocity,
	input wire logic        step_start,
	input wire logic        run_enable,
	input wire logic        jog_active,
	input wire logic        standstill_mon_en,
	input wire logic        halt_req
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	a_ack_follows_req: assert property ((param_wr || param_rd) |=> param_ack)
		else $error("missing ack");
	a_ack_needs_req: assert property (!(param_wr || param_rd) |=> !param_ack)
		else $error("spurious ack");
	a_err_with_ack: assert property (param_err |-> param_ack)
		else $error("err without ack");
	a_vel_clamped: assert property (move_velocity <= $past(ramp_v_max))
		else $error("velocity above ramp max");
	a_step_one_pulse: assert property (step_start |=> !step_start)
		else $error("step start too long");
	a_mon_only_jog: assert property (standstill_mon_en |-> jog_active)
		else $error("monitor outside jog");
	a_run_only_jog: assert property (run_enable |-> jog_active)
		else $error("run outside jog");
	a_halt_stops_run: assert property (halt_req |-> ##[1:2] !run_enable)
		else $error("run kept under halt");
	c_step: cover property (step_start);
	c_run: cover property (run_enable && standstill_mon_en);
	c_err: cover property (param_err);
endmodule

// ---- dv/motion_core_model.sv ----
// Motion core model: finishes a step a few cycles after it starts.
// Assumes step and run commands from the jog sequencer on core_clk.
`timescale 1ns/1ps
module motion_core_model #(
	parameter int DLY = 4
) (
	input  wire logic core_clk,
	input  wire logic rst_b,
	input  wire logic step_start,
	input  wire logic run_enable,
	output logic      step_done,
	output logic      motor_standstill
);
	int cnt;
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			cnt <= 0;
			step_done <= 1'b0;
			motor_standstill <= 1'b1;
		end else begin
			step_done <= (cnt == 1);
			if (step_start)
				cnt <= DLY;
			else if (cnt != 0)
				cnt <= cnt - 1;
			motor_standstill <= !run_enable && cnt == 0 && !step_start;
		end
	end
endmodule

// ---- dv/tb.sv ----
// Top testbench for the jog parameter and sequencing block.
// Assumes the motion core model answers steps; dwell uses 10-cycle ms.
`timescale 1ns/1ps
module tb;
	import jog_pkg::*;
	logic core_clk = 0, rst_b = 0, param_wr = 0, param_rd = 0;
	logic [15:0] param_addr = '0;
	logic [31:0] param_wdata = '0, ramp_v_max = 32'h0000_1000;
	logic [31:0] param_rdata, move_velocity, step_target, rv;
	logic param_ack, param_err, jog_active, move_neg, step_start, re;
	logic run_enable, standstill_mon_en, step_done, motor_standstill;
	logic local_mode = 1, sig_jog_pos = 0, sig_jog_neg = 0;
	logic sig_fast_sel = 0, fast_sel_func_en = 0, halt_req = 0;
	logic quick_stop = 0, error_detected = 0;
	int error_cnt = 0, num_checks = 0, wn;
	logic [15:0] ra [6] = '{ADDR_INPUT_METHOD, ADDR_BUS_METHOD,
		ADDR_SLOW_VEL, ADDR_FAST_VEL, ADDR_STEP_DIST, ADDR_DWELL};
	logic [31:0] rr [6] = '{{16'h0000, RST_INPUT_METHOD},
		{16'h0000, RST_BUS_METHOD}, RST_SLOW_VEL, RST_FAST_VEL,
		RST_STEP_DIST, {16'h0000, RST_DWELL}};
	logic [31:0] bad [6] = '{32'h0000_0002, 32'h0000_0002,
		32'h8000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_8000};
	always #5 core_clk = ~core_clk;
	jog_mode_parameter_control #(.MS_CYCLES(10))
		i_jog_mode_parameter_control (
		.core_clk(core_clk), .rst_b(rst_b), .param_wr(param_wr),
		.param_rd(param_rd), .param_addr(param_addr),
		.param_wdata(param_wdata), .param_rdata(param_rdata),
		.param_ack(param_ack), .param_err(param_err),
		.local_mode(local_mode), .sig_jog_pos(sig_jog_pos),
		.sig_jog_neg(sig_jog_neg), .sig_fast_sel(sig_fast_sel),
		.fast_sel_func_en(fast_sel_func_en), .ramp_v_max(ramp_v_max),
		.step_done(step_done), .motor_standstill(motor_standstill),
		.halt_req(halt_req), .quick_stop(quick_stop),
		.error_detected(error_detected), .jog_active(jog_active),
		.move_neg(move_neg), .move_velocity(move_velocity),
		.step_start(step_start), .step_target(step_target),
		.run_enable(run_enable), .standstill_mon_en(standstill_mon_en));
	motion_core_model i_motion_core_model (
		.core_clk(core_clk), .rst_b(rst_b), .step_start(step_start),
		.run_enable(run_enable), .step_done(step_done),
		.motor_standstill(motor_standstill));
	////////////////////////////////////////
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task acc(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(negedge core_clk);
		param_wr = w;
		param_rd = !w;
		param_addr = a;
		param_wdata = d;
		@(negedge core_clk);
		param_wr = 0;
		param_rd = 0;
		re = param_err;
		rv = param_rdata;
		chk(param_ack, 1);
	endtask
	// Waits on step start, run or active; a bounded wait avoids a hang.
	task wfor(input int s, input logic v);
		wn = 0;
		while ((s == 0 ? step_start : s == 1 ? run_enable : jog_active)
				!== v && wn < 300) begin
			@(negedge core_clk);
			wn++;
		end
		chk(wn < 300, 1);
	endtask
	task wrap_up;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		repeat (5) @(negedge core_clk);
		rst_b = 1;
		for (int i = 0; i < 6; i++) begin
			acc(1, ra[i], bad[i]);
			chk(re, 1);
			acc(0, ra[i], 0);
			chk(rv, rr[i]);
		end
		acc(0, 16'h1234, 0);
		chk(re, 1);
		$display("test reset and refusal done");
		acc(1, ADDR_FAST_VEL, MAX_POS32);
		chk(re, 0);
		acc(1, ADDR_SLOW_VEL, 32'h0000_0064);
		ramp_v_max = 32'h0000_0050;
		repeat (3) @(negedge core_clk);
		chk(move_velocity, 32'h0000_0050);
		ramp_v_max = 32'h0000_1000;
		sig_fast_sel = 1;
		repeat (3) @(negedge core_clk);
		chk(move_velocity, 32'h0000_0064);
		fast_sel_func_en = 1;
		repeat (3) @(negedge core_clk);
		chk(move_velocity, 32'h0000_1000);
		sig_fast_sel = 0;
		$display("test velocity select done");
		acc(1, ADDR_STEP_DIST, 32'h0000_001E);
		acc(1, ADDR_DWELL, 32'h0000_0003);
		sig_jog_pos = 1;
		wfor(0, 1);
		chk(step_target, 32'h0000_001E);
		wfor(1, 1);
		chk(wn >= 33 && wn <= 45, 1);
		chk(standstill_mon_en, 1);
		sig_jog_pos = 0;
		wfor(2, 0);
		chk(run_enable, 0);
		$display("test input step jog done");
		local_mode = 0;
		acc(1, ADDR_BUS_METHOD, 0);
		acc(1, ADDR_MOVE_WORD, 32'h0000_0005);
		wfor(1, 1);
		chk(wn <= 4, 1);
		chk(standstill_mon_en, 0);
		chk(move_velocity, 32'h0000_1000);
		halt_req = 1;
		wfor(1, 0);
		chk(wn <= 3, 1);
		halt_req = 0;
		acc(1, ADDR_MOVE_WORD, 0);
		wfor(2, 0);
		$display("test bus jog and halt done");
		sig_jog_neg = 1;
		for (int k = 0; k < 2; k++) begin
			wfor(0, 1);
			@(negedge core_clk);
			chk(move_neg, 1);
			chk(standstill_mon_en, 1);
			if (k == 0)
				quick_stop = 1;
			else
				error_detected = 1;
			wfor(2, 0);
			chk(run_enable, 0);
			quick_stop = 0;
			error_detected = 0;
		end
		sig_jog_neg = 0;
		$display("test input jog stops done");
		wrap_up;
	end
	initial begin
		#100us;
		error_cnt++;
		$display("[FAIL] %0t watchdog expired", $time);
		wrap_up;
	end
endmodule
bind jog_mode_parameter_control jog_properties i_jog_properties (
	.core_clk(core_clk),
	.rst_b(rst_b),
	.param_wr(param_wr),
	.param_rd(param_rd),
	.param_ack(param_ack),
	.param_err(param_err),
	.ramp_v_max(ramp_v_max),
	.move_velocity(move_velocity),
	.step_start(step_start),
	.run_enable(run_enable),
	.jog_active(jog_active),
	.standstill_mon_en(standstill_mon_en),
	.halt_req(halt_req)
);
